// file: rtl/mrd_pkg.sv
// Summary of operation
// - Partial release reports three-bit result codes
// - Completion flag bit 29, other result bits zero
// - Receive path moves frame data into buffer RAM
// - Enable call starts DMA; disable call stops it
// - Frame present: request one 2048-byte long buffer
// - Write frame words consecutively from buffer start
// - Finished frame pushes word count and address record
// - Processor-readable queue holds 64 frame records
// - Return unused buffer tail by partial release
// - Skip tail return when 128 bytes or less
// - Acquisition failure: discard frame, release whole buffer
// - Filtered frame: discard and release whole buffer
// - Disable at <=4092 words: release buffer, stop immediately
// - Whole-buffer release cases write no queue record
// - Error interrupt; cause read by error-status call
// - Completion interrupt active while queue holds records
// - Completion interrupt drops when last record read
// - Unfiltered frame raises valid or error frame interrupt
// - All frame sources enabled at reset; filter disables
// - Record: count at 27:16, address 26:11 at 15:0
// - Error status: bit0 capacity, bit2 big, bit3 forced
package mrd_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] ADDR_CALL_CMD = 8'h00;
  localparam logic [7:0] ADDR_CALL_ARG1 = 8'h04;
  localparam logic [7:0] ADDR_CALL_ARG2 = 8'h08;
  localparam logic [7:0] ADDR_CALL_RES = 8'h0C;
  localparam logic [7:0] ADDR_CALL_RES2 = 8'h10;
  localparam logic [7:0] ADDR_INFO_Q = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  // Call codes written to the command register
  localparam logic [3:0] CMD_ENABLE = 4'h1;
  localparam logic [3:0] CMD_DISABLE = 4'h2;
  localparam logic [3:0] CMD_FILTER = 4'h3;
  localparam logic [3:0] CMD_ERRSTAT = 4'h4;
  localparam logic [3:0] CMD_PART_REL = 4'h5;
  // Result codes
  localparam logic [2:0] RES_OK = 3'h0;
  localparam logic [2:0] RES_INVALID = 3'h2;
  localparam logic [2:0] RES_UNDEF = 3'h3;
  localparam logic [2:0] RES_FREED = 3'h4;
  localparam int RES_DONE_BIT = 29;
  // Allocator operations and answer codes
  localparam logic [1:0] OP_GET = 2'h1;
  localparam logic [1:0] OP_FREE = 2'h2;
  localparam logic [1:0] OP_PART = 2'h3;
  localparam logic [1:0] ACODE_UNDEF = 2'h1;
  localparam logic [1:0] ACODE_FREED = 2'h2;
  // Sizes and limits
  localparam int BUF_BYTES = 2048;
  localparam int SEG_BYTES = 128;
  localparam int QUEUE_DEPTH = 64;
  localparam logic [12:0] BUF_WORDS = 13'(BUF_BYTES / 4);
  localparam logic [12:0] PART_SKIP_WORDS = 13'((BUF_BYTES - SEG_BYTES) / 4);
  localparam logic [12:0] DIS_LIMIT_WORDS = 13'hFFC;
  localparam logic [12:0] BIG_FRAME_WORDS = 13'h1000;
  localparam logic [4:0] ADDR_TOP = 5'h01;
  // Error status bits
  localparam int ERR_NO_SPACE = 0;
  localparam int ERR_BIG = 2;
  localparam int ERR_FORCED = 3;
  // Reset values
  localparam logic [8:0] FILTER_RESET = 9'h1FF;
  localparam logic [3:0] ERR_RESET = 4'h0;

  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_GET = 7'h02,
    S_XFER = 7'h04,
    S_PART = 7'h08,
    S_PUSH = 7'h10,
    S_FREE = 7'h20,
    S_DROP = 7'h40
  } mrd_state_t;

  typedef struct packed {
    logic [1:0] op;
    logic [31:0] addr;
    logic [31:0] part_addr;
  } mrd_alloc_req_t;

  typedef struct packed {
    logic [11:0] words;
    logic [15:0] base;
  } mrd_rec_t;

  typedef struct packed {
    logic we;
    logic [31:0] addr;
    logic [31:0] data;
  } mrd_ram_wr_t;
endpackage

// file: rtl/mrd_rx_dma.sv
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module mrd_rx_dma #(
  parameter int SRC_W = 8
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic RXF_AVAIL,
  input wire logic RXF_VALID,
  input wire logic [31:0] RXF_DATA,
  input wire logic RXF_LAST,
  input wire logic [SRC_W-1:0] RXF_STATUS,
  output logic RXF_POP,
  output logic ALLOC_REQ,
  output mrd_pkg::mrd_alloc_req_t ALLOC_REQ_INFO,
  input wire logic ALLOC_ACK,
  input wire logic ALLOC_OK,
  input wire logic [1:0] ALLOC_CODE,
  input wire logic [31:0] ALLOC_BUF,
  output mrd_pkg::mrd_ram_wr_t RAM_WR,
  output logic RX_DONE_IRQ,
  output logic VALID_FRAME_IRQ,
  output logic ERROR_FRAME_IRQ,
  output logic ERROR_IRQ
);
  import mrd_pkg::*;

  mrd_state_t state;
  logic en;
  logic dis_pend;
  logic part_pend;
  logic sw_part;
  logic drop;
  logic keep;
  logic busy;
  logic res_done;
  logic [7:0] res_low;
  logic [31:0] arg1;
  logic [31:0] arg2;
  logic [31:0] buf_addr;
  logic [12:0] wcount;
  logic [12:0] next_count;
  logic [SRC_W:0] filter_en;
  logic [3:0] err_flags;
  logic filtered;
  logic is_err;
  logic force_stop;
  logic call_wr;
  logic push;
  logic pop;
  logic ev_nospace;
  logic ev_big;
  logic ev_forced;
  logic errstat_call;
  mrd_rec_t rec_in;
  mrd_rec_t mem [QUEUE_DEPTH];
  logic [5:0] wptr;
  logic [5:0] rptr;
  logic [6:0] q_count;

  // Call decode; a new call is refused while a slow one is pending
  assign call_wr = WR && (ADDR == ADDR_CALL_CMD);
  assign busy = dis_pend || part_pend;
  assign errstat_call = call_wr && !busy && (WDATA[3:0] == CMD_ERRSTAT);
  assign next_count = (wcount == 13'h1FFF) ? wcount : wcount + 13'h0001;

  // Frame judgment at the last word; bit SRC_W enables the good-frame source
  assign is_err = |RXF_STATUS;
  assign filtered = is_err ? |(RXF_STATUS & ~filter_en[SRC_W-1:0]) : !filter_en[SRC_W];
  assign force_stop = dis_pend && (wcount <= DIS_LIMIT_WORDS);

  // Pop is combinational so that a word moves every cycle it is offered
  assign pop = RXF_VALID && ((state == S_XFER && !force_stop) || state == S_DROP);
  assign RXF_POP = pop;
  assign push = (state == S_PUSH);

  // Error events feeding the sticky status
  assign ev_nospace = (state == S_GET && ALLOC_ACK && !ALLOC_OK)
    || (state == S_XFER && pop && wcount >= BUF_WORDS);
  assign ev_big = state == S_XFER && pop && next_count == BIG_FRAME_WORDS;
  assign ev_forced = state == S_XFER && force_stop;

  // Main sequencer and call handling
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      state <= S_IDLE;
      en <= 1'b0;
      dis_pend <= 1'b0;
      part_pend <= 1'b0;
      sw_part <= 1'b0;
      drop <= 1'b0;
      keep <= 1'b0;
      res_done <= 1'b0;
      res_low <= 8'h00;
      filter_en <= FILTER_RESET[SRC_W:0];
      buf_addr <= 32'h0000_0000;
      wcount <= 13'h0000;
      rec_in <= '0;
      ALLOC_REQ <= 1'b0;
      ALLOC_REQ_INFO <= '0;
      VALID_FRAME_IRQ <= 1'b0;
      ERROR_FRAME_IRQ <= 1'b0;
    end
    else
    begin
      VALID_FRAME_IRQ <= 1'b0;
      ERROR_FRAME_IRQ <= 1'b0;
      if (call_wr && !busy)
      begin
        res_done <= 1'b0;
        case (WDATA[3:0])
          CMD_ENABLE:
          begin
            en <= 1'b1;
            res_low <= {5'h00, RES_OK};
            res_done <= 1'b1;
          end
          CMD_DISABLE: dis_pend <= 1'b1;
          CMD_FILTER:
          begin
            filter_en <= arg1[SRC_W:0];
            res_low <= {5'h00, RES_OK};
            res_done <= 1'b1;
          end
          CMD_ERRSTAT:
          begin
            res_low <= {4'h0, err_flags};
            res_done <= 1'b1;
          end
          CMD_PART_REL:
          begin
            // Tail start must fall inside the named buffer
            if (arg2 < arg1 || arg2 >= arg1 + 32'(BUF_BYTES))
            begin
              res_low <= {5'h00, RES_INVALID};
              res_done <= 1'b1;
            end
            else
            begin
              part_pend <= 1'b1;
            end
          end
          default:
          begin
            res_low <= {5'h00, RES_INVALID};
            res_done <= 1'b1;
          end
        endcase
      end
      case (state)
        S_IDLE:
        begin
          if (dis_pend)
          begin
            en <= 1'b0;
            dis_pend <= 1'b0;
            res_low <= {5'h00, RES_OK};
            res_done <= 1'b1;
          end
          else if (part_pend)
          begin
            sw_part <= 1'b1;
            ALLOC_REQ <= 1'b1;
            ALLOC_REQ_INFO <= '{op: OP_PART, addr: arg1, part_addr: arg2};
            state <= S_PART;
          end
          else if (en && RXF_AVAIL && q_count < 7'(QUEUE_DEPTH))
          begin
            // Holding off while the queue is full keeps records from being lost
            ALLOC_REQ <= 1'b1;
            ALLOC_REQ_INFO <= '{op: OP_GET, addr: 32'h0000_0000, part_addr: 32'h0000_0000};
            wcount <= 13'h0000;
            state <= S_GET;
          end
        end
        S_GET:
        begin
          if (ALLOC_ACK)
          begin
            buf_addr <= ALLOC_BUF;
            if (ALLOC_OK)
            begin
              ALLOC_REQ <= 1'b0;
              state <= S_XFER;
            end
            else
            begin
              drop <= 1'b1;
              ALLOC_REQ_INFO <= '{op: OP_FREE, addr: ALLOC_BUF, part_addr: 32'h0000_0000};
              state <= S_FREE;
            end
          end
        end
        S_XFER:
        begin
          if (force_stop)
          begin
            keep <= 1'b1;
            ALLOC_REQ <= 1'b1;
            ALLOC_REQ_INFO <= '{op: OP_FREE, addr: buf_addr, part_addr: 32'h0000_0000};
            state <= S_FREE;
          end
          else if (pop)
          begin
            wcount <= next_count;
            if (RXF_LAST)
            begin
              rec_in <= '{words: next_count[11:0], base: buf_addr[26:11]};
              if (filtered)
              begin
                // Frame already drained, so only the buffer goes back
                ALLOC_REQ <= 1'b1;
                ALLOC_REQ_INFO <= '{op: OP_FREE, addr: buf_addr, part_addr: 32'h0000_0000};
                state <= S_FREE;
              end
              else
              begin
                VALID_FRAME_IRQ <= !is_err;
                ERROR_FRAME_IRQ <= is_err;
                if (next_count < PART_SKIP_WORDS)
                begin
                  ALLOC_REQ <= 1'b1;
                  ALLOC_REQ_INFO <= '{op: OP_PART, addr: buf_addr,
                    part_addr: buf_addr + 32'({next_count, 2'b00})};
                  state <= S_PART;
                end
                else
                begin
                  state <= S_PUSH;
                end
              end
            end
          end
        end
        S_PART:
        begin
          if (ALLOC_ACK)
          begin
            ALLOC_REQ <= 1'b0;
            if (sw_part)
            begin
              sw_part <= 1'b0;
              part_pend <= 1'b0;
              res_done <= 1'b1;
              case (ALLOC_CODE)
                ACODE_UNDEF: res_low <= {5'h00, RES_UNDEF};
                ACODE_FREED: res_low <= {5'h00, RES_FREED};
                default: res_low <= {5'h00, RES_OK};
              endcase
              state <= S_IDLE;
            end
            else
            begin
              state <= S_PUSH;
            end
          end
        end
        S_PUSH: state <= S_IDLE;
        S_FREE:
        begin
          if (ALLOC_ACK)
          begin
            ALLOC_REQ <= 1'b0;
            keep <= 1'b0;
            if (keep)
            begin
              en <= 1'b0;
              dis_pend <= 1'b0;
              res_low <= {5'h00, RES_OK};
              res_done <= 1'b1;
            end
            state <= drop ? S_DROP : S_IDLE;
          end
        end
        S_DROP:
        begin
          if (pop && RXF_LAST)
          begin
            drop <= 1'b0;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Buffer RAM write port, one word per pop inside the buffer at consecutive addresses
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      RAM_WR <= '0;
    end
    else
    begin
      // Words past the buffer end are dropped rather than spill into a neighbour
      RAM_WR.we <= state == S_XFER && pop && wcount < BUF_WORDS;
      RAM_WR.addr <= buf_addr + 32'({wcount, 2'b00});
      RAM_WR.data <= RXF_DATA;
    end
  end

  // Sticky error causes; a new event wins over the status call's clear
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      err_flags <= ERR_RESET;
    end
    else
    begin
      err_flags[ERR_NO_SPACE] <= ev_nospace || (err_flags[ERR_NO_SPACE] && !errstat_call);
      err_flags[1] <= 1'b0;
      err_flags[ERR_BIG] <= ev_big || (err_flags[ERR_BIG] && !errstat_call);
      err_flags[ERR_FORCED] <= ev_forced || (err_flags[ERR_FORCED] && !errstat_call);
    end
  end
  assign ERROR_IRQ = |err_flags;

  // Receive-information queue, one storage word per entry
  for (genvar i = 0; i < QUEUE_DEPTH; i++)
  begin : g_q
    always_ff @(posedge CLK)
    begin
      if (RST)
      begin
        mem[i] <= '0;
      end
      else if (push && wptr == 6'(i))
      begin
        mem[i] <= rec_in;
      end
    end
  end

  logic q_read;
  assign q_read = RD && ADDR == ADDR_INFO_Q && q_count != 7'h00;

  // Queue pointers; push is never issued when full
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      wptr <= 6'h00;
      rptr <= 6'h00;
      q_count <= 7'h00;
    end
    else
    begin
      if (push)
      begin
        wptr <= wptr + 6'h01;
      end
      if (q_read)
      begin
        rptr <= rptr + 6'h01;
      end
      q_count <= q_count + 7'(push) - 7'(q_read);
    end
  end
  assign RX_DONE_IRQ = q_count != 7'h00;

  // Register read port, data one cycle after the strobe
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      RDATA <= 32'h0000_0000;
    end
    else if (RD)
    begin
      case (ADDR)
        ADDR_CALL_ARG1: RDATA <= arg1;
        ADDR_CALL_ARG2: RDATA <= arg2;
        ADDR_CALL_RES: RDATA <= {2'h0, res_done, 21'h000000, res_low};
        ADDR_CALL_RES2: RDATA <= 32'h0000_0000;
        ADDR_INFO_Q: RDATA <= q_read ? {4'h0, mem[rptr]} : 32'h0000_0000;
        ADDR_STATUS: RDATA <= {23'h000000, en, 1'b0, q_count};
        default: RDATA <= 32'h0000_0000;
      endcase
    end
    else
    begin
      RDATA <= 32'h0000_0000;
    end
  end

  // Argument registers
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      arg1 <= 32'h0000_0000;
      arg2 <= 32'h0000_0000;
    end
    else if (WR && ADDR == ADDR_CALL_ARG1)
    begin
      arg1 <= WDATA;
    end
    else if (WR && ADDR == ADDR_CALL_ARG2)
    begin
      arg2 <= WDATA;
    end
  end

  // Checks
  reset_idle_a: assert property (@(posedge CLK) RST |=> state == S_IDLE && !RX_DONE_IRQ && !ERROR_IRQ)
    else $error("not idle after reset");
  get_cause_a: assert property (@(posedge CLK) disable iff (RST)
    $rose(ALLOC_REQ) && ALLOC_REQ_INFO.op == OP_GET |-> $past(en) && $past(RXF_AVAIL))
    else $error("buffer request without enabled frame");
  seq_addr_a: assert property (@(posedge CLK) disable iff (RST)
    RAM_WR.we && $past(RAM_WR.we) |-> RAM_WR.addr == $past(RAM_WR.addr) + 32'h4)
    else $error("ram writes not consecutive");
  done_irq_a: assert property (@(posedge CLK) disable iff (RST)
    push && q_count == 7'h00 |=> RX_DONE_IRQ ##1 (RX_DONE_IRQ || $past(q_read)))
    else $error("completion irq not raised");
  last_read_a: assert property (@(posedge CLK) disable iff (RST)
    q_count == 7'h01 && q_read && !push |=> !RX_DONE_IRQ)
    else $error("completion irq kept after last read");
  free_norec_a: assert property (@(posedge CLK) disable iff (RST)
    state == S_FREE |=> q_count <= $past(q_count))
    else $error("record written on whole release");
  tail_skip_a: assert property (@(posedge CLK) disable iff (RST)
    state == S_PART && !sw_part |-> wcount < PART_SKIP_WORDS)
    else $error("tail returned below one segment");
  disable_now_a: assert property (@(posedge CLK) disable iff (RST)
    state == S_XFER && force_stop |=> state == S_FREE && !RXF_POP)
    else $error("disable did not stop transfer");
  result_zero_a: assert property (@(posedge CLK) disable iff (RST)
    RD && ADDR == ADDR_CALL_RES |=> RDATA[28:8] == 21'h000000 && RDATA[31:30] == 2'h0)
    else $error("unused result bits not zero");
  queue_bound_a: assert property (@(posedge CLK) disable iff (RST) q_count <= 7'h40)
    else $error("queue over depth");
  frame_irq_a: assert property (@(posedge CLK) disable iff (RST)
    !(VALID_FRAME_IRQ && ERROR_FRAME_IRQ))
    else $error("both frame irqs at once");
endmodule

// file: tb/mrd_far_model.sv
`timescale 1ns/1ps
module mrd_far_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic rxf_pop,
  input wire logic alloc_req,
  input wire mrd_pkg::mrd_alloc_req_t alloc_info,
  output logic rxf_avail,
  output logic rxf_valid,
  output logic [31:0] rxf_data,
  output logic rxf_last,
  output logic [7:0] rxf_status,
  output logic alloc_ack,
  output logic alloc_ok,
  output logic [1:0] alloc_code,
  output logic [31:0] alloc_buf
);
  import mrd_pkg::*;
  int left = 0;
  int sent = 0;
  int nb = 1;
  int dly = 1;
  int wt = 0;
  int tick = 0;
  logic slow = 1'b0;
  logic grant = 1'b1;
  logic [1:0] pcode = 2'h0;
  logic [7:0] st = 8'h00;
  logic [31:0] cur_buf = 32'h0;
  mrd_alloc_req_t log[$];

  // One frame at a time; a slow FIFO idles every other cycle
  assign rxf_avail = left > 0;
  assign rxf_valid = left > 0 && !(slow && tick[0]);
  assign rxf_last = rxf_valid && left == 1;
  // Idle data keep moving and status is inverted off the last word, so a stale word never looks valid
  assign rxf_data = rxf_valid ? {16'hA5A5, sent[15:0]} : {16'h5A5A, tick[15:0]};
  assign rxf_status = rxf_last ? st : ~st;

  // Word consumption
  always @(posedge clk)
  begin
    tick <= tick + 1;
    if (rxf_pop && rxf_valid)
    begin
      sent <= sent + 1;
      left <= left - 1;
    end
  end

  // Allocator answers after dly cycles; answer fields are garbage off the ack
  always @(posedge clk)
  begin
    alloc_ack <= 1'b0;
    alloc_ok <= ~alloc_ok;
    alloc_code <= ~alloc_code;
    alloc_buf <= ~alloc_buf;
    wt <= alloc_req ? wt + 1 : 0;
    if (rst)
    begin
      {alloc_ok, alloc_code, alloc_buf} <= '0;
      wt <= 0;
    end
    else if (alloc_req && !alloc_ack && wt >= dly)
    begin
      alloc_ack <= 1'b1;
      wt <= 0;
      log.push_back(alloc_info);
      alloc_ok <= grant;
      alloc_code <= pcode;
      alloc_buf <= 32'h0800_0000 + (32'(nb) << 11);
      if (alloc_info.op == OP_GET && grant)
      begin
        cur_buf <= 32'h0800_0000 + (32'(nb) << 11);
        nb <= nb + 1;
      end
    end
  end
endmodule

// file: tb/tb_mac_rx_dma_controller.sv
`timescale 1ns/1ps
module tb_mac_rx_dma_controller;
  import mrd_pkg::*;
  logic clk, rst, wr, rd, avail, valid, last, pop, req, ack, ok;
  logic done_irq, vf_irq, ef_irq, err_irq;
  logic [1:0] code;
  logic [7:0] addr, status;
  logic [31:0] wdata, rdata, rdat, abuf, d;
  logic [2:0] exp_res [3] = '{RES_OK, RES_UNDEF, RES_FREED};
  mrd_alloc_req_t info;
  mrd_ram_wr_t ram_wr;
  int failures, checks, cyc, idx, n_vf, n_ef, s;

  mrd_rx_dma u_dut (
    .CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .RXF_AVAIL(avail), .RXF_VALID(valid), .RXF_DATA(rdat), .RXF_LAST(last),
    .RXF_STATUS(status), .RXF_POP(pop), .ALLOC_REQ(req), .ALLOC_REQ_INFO(info),
    .ALLOC_ACK(ack), .ALLOC_OK(ok), .ALLOC_CODE(code), .ALLOC_BUF(abuf), .RAM_WR(ram_wr),
    .RX_DONE_IRQ(done_irq), .VALID_FRAME_IRQ(vf_irq), .ERROR_FRAME_IRQ(ef_irq),
    .ERROR_IRQ(err_irq)
  );
  mrd_far_model u_far (
    .clk(clk), .rst(rst), .rxf_pop(pop), .alloc_req(req), .alloc_info(info),
    .rxf_avail(avail), .rxf_valid(valid), .rxf_data(rdat), .rxf_last(last),
    .rxf_status(status), .alloc_ack(ack), .alloc_ok(ok), .alloc_code(code), .alloc_buf(abuf)
  );

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Cycle ceiling cuts a hung handshake short
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      failures++;
      wrap_up();
    end
  end

  // Each buffer word must follow the last one, carrying the FIFO word
  always @(posedge clk)
  begin
    if (ram_wr.we === 1'b1)
    begin
      chk("ram addr", ram_wr.addr, u_far.cur_buf + 32'(4 * idx));
      chk("ram data", ram_wr.data, {16'hA5A5, 16'(idx)});
      idx++;
    end
    if (vf_irq === 1'b1)
      n_vf++;
    if (ef_irq === 1'b1)
      n_ef++;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (failures == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  // Arguments first, then the command; poll the complete flag, bounded
  task automatic call(input logic [3:0] c, input logic [31:0] a1, input logic [31:0] a2);
    int n;
    wr_reg(ADDR_CALL_ARG1, a1);
    wr_reg(ADDR_CALL_ARG2, a2);
    wr_reg(ADDR_CALL_CMD, {28'h0, c});
    n = 0;
    do
    begin
      rd_reg(ADDR_CALL_RES, d);
      n++;
    end
    while (d[RES_DONE_BIT] !== 1'b1 && n < 200);
    chk("call done", 32'(d[RES_DONE_BIT]), 32'h1);
  endtask

  task automatic load(input int len, input logic [7:0] st);
    #2;
    u_far.log.delete();
    idx = 0;
    u_far.st = st;
    u_far.sent = 0;
    u_far.left = len;
  endtask

  // Frame gone and allocator quiet for eight cycles
  task automatic settle();
    int q;
    q = 0;
    for (int n = 0; n < 5000 && q < 8; n++)
    begin
      @(posedge clk);
      q = (u_far.left == 0 && req === 1'b0) ? q + 1 : 0;
    end
  endtask

  task automatic frame(input int len, input logic [7:0] st);
    load(len, st);
    settle();
  endtask

  task automatic ops(input int n, input logic [1:0] op2, input int len);
    chk("op count", 32'(u_far.log.size()), 32'(n));
    chk("op get", 32'(u_far.log[0].op), 32'(OP_GET));
    if (n == 2)
    begin
      chk("op rel", 32'(u_far.log[1].op), 32'(op2));
      if (len >= 0)
        chk("rel addr", u_far.log[1].addr, u_far.cur_buf);
      if (op2 == OP_PART)
        chk("part addr", u_far.log[1].part_addr, u_far.cur_buf + 32'(4 * len));
    end
  endtask

  task automatic rec(input int len, input logic [31:0] b);
    rd_reg(ADDR_INFO_Q, d);
    chk("record", d, {4'h0, 12'(len), b[26:11]});
  endtask

  task automatic good(input int len);
    ops(len < 480 ? 2 : 1, OP_PART, len);
    chk("done on", 32'(done_irq), 32'h1);
    rec(len, u_far.cur_buf);
    chk("done off", 32'(done_irq), 32'h0);
  endtask

  initial
  begin
    {wr, rd, addr, wdata} = '0;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("idle outs", 32'({req, pop, done_irq, vf_irq, ef_irq, err_irq}), 32'h0);
    rd_reg(ADDR_STATUS, d);
    chk("status", d, 32'h0);
    rd_reg(8'hF0, d);
    chk("unmapped", d, 32'h0);
    // A frame waits while the DMA is still off
    load(3, 8'h00);
    repeat (12) @(posedge clk);
    chk("req off", 32'({req, pop}), 32'h0);
    call(CMD_ENABLE, 0, 0);
    chk("en result", d, 32'h2000_0000);
    settle();
    good(3);
    // Tail return just above and at one segment
    for (int l = 479; l < 481; l++)
    begin
      u_far.dly = l - 478;
      frame(l, 8'h00);
      good(l);
    end
    // Source 0 filtered; source 1 still passes as an error frame
    call(CMD_FILTER, 32'h1FE, 0);
    frame(4, 8'h01);
    ops(2, OP_FREE, 4);
    rd_reg(ADDR_STATUS, d);
    chk("filtered q", 32'(d[6:0]), 32'h0);
    frame(2, 8'h02);
    ops(2, OP_PART, 2);
    rec(2, u_far.cur_buf);
    chk("valid irqs", 32'(n_vf), 32'd3);
    chk("error irqs", 32'(n_ef), 32'd1);
    call(CMD_FILTER, 32'h1FF, 0);
    // Allocator out of space
    u_far.grant = 1'b0;
    frame(4, 8'h00);
    u_far.grant = 1'b1;
    ops(2, OP_FREE, -1);
    chk("err irq", 32'(err_irq), 32'h1);
    rd_reg(ADDR_STATUS, d);
    chk("nospace q", 32'(d[6:0]), 32'h0);
    call(CMD_ERRSTAT, 0, 0);
    chk("errstat", 32'(d[3:0]), 32'h1);
    chk("err clr", 32'(err_irq), 32'h0);
    // Allocator answer codes 0, 1 and 2 of the partial-release call
    for (int i = 0; i < 3; i++)
    begin
      u_far.pcode = 2'(i);
      call(CMD_PART_REL, 32'h0800_1000, 32'h0800_1040);
      chk("part res", d, {2'b00, 1'b1, 26'h0, exp_res[i]});
    end
    chk("part arg", u_far.log[2].part_addr, 32'h0800_1040);
    call(CMD_PART_REL, 32'h0800_1000, 32'h0800_1800);
    chk("part bad", d, 32'h2000_0002);
    call(4'hF, 0, 0);
    chk("bad cmd", d, 32'h2000_0002);
    rd_reg(ADDR_CALL_RES2, d);
    chk("res2", d, 32'h0);
    // Fill the queue to its depth, then drain it
    s = u_far.nb;
    for (int k = 0; k < QUEUE_DEPTH; k++)
      frame(1, 8'h00);
    rd_reg(ADDR_STATUS, d);
    chk("q full", 32'(d[6:0]), 32'h40);
    for (int k = 0; k < QUEUE_DEPTH; k++)
    begin
      chk("done held", 32'(done_irq), 32'h1);
      rec(1, 32'h0800_0000 + (32'(s + k) << 11));
    end
    chk("done drop", 32'(done_irq), 32'h0);
    rd_reg(ADDR_INFO_Q, d);
    chk("q empty", d, 32'h0);
    // Oversize frame overruns the buffer, then reaches the big-frame mark
    frame(4096, 8'h00);
    ops(1, OP_PART, 4096);
    rd_reg(ADDR_INFO_Q, d);
    chk("big base", 32'(d[15:0]), 32'(u_far.cur_buf[26:11]));
    call(CMD_ERRSTAT, 0, 0);
    chk("oversize", 32'(d[3:0]), 32'h5);
    // Disable in mid-frame with a slow FIFO and allocator
    u_far.slow = 1'b1;
    u_far.dly = 4;
    load(300, 8'h00);
    for (int n = 0; n < 2000 && u_far.sent < 20; n++)
      @(posedge clk);
    call(CMD_DISABLE, 0, 0);
    s = u_far.sent;
    repeat (10) @(posedge clk);
    chk("pops stop", 32'(u_far.sent), 32'(s));
    ops(2, OP_FREE, 0);
    rd_reg(ADDR_STATUS, d);
    chk("dis status", d, 32'h0);
    call(CMD_ERRSTAT, 0, 0);
    chk("forced", 32'(d[3]), 32'h1);
    wrap_up();
  end
endmodule
